//--- aaf_regs.sv
// The implementer's own choices: the register offsets and the APB slave port.
`timescale 1ns/1ns
`default_nettype none
module aaf_regs #(
  parameter int RC_DIV = 8
) (
  // Clock and reset
  input  wire logic        pclk,
  input  wire logic        presetn,
  // APB slave
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [7:0]  paddr,
  input  wire logic [31:0] pwdata,
  output logic [31:0]      prdata,
  output logic             pready,
  output logic             pslverr,
  // Converter core
  input  wire logic        conv_trigger,
  input  wire logic        conv_valid,
  input  wire logic [11:0] conv_data,
  output logic             conv_start,
  output logic [4:0]       extra_sample_capacitance,
  output logic             threshold_check
);
  import aaf_pkg::*;

  logic [7:0]  acq_low_reg;
  logic [4:0]  acq_high_reg;
  logic [7:0]  pre_low_reg;
  logic [4:0]  pre_high_reg;
  logic [4:0]  cap_reg;
  logic [7:0]  repeat_threshold_reg;
  logic [7:0]  trigger_repeat_counter_reg;
  logic [11:0] conversion_result_reg;
  logic [17:0] running_sum_reg;
  logic [15:0] lpf_reg;
  logic        result_justify_select_reg;
  logic        conversion_clock_select_reg;
  logic [2:0]  mode_reg;
  logic [3:0]  result_shift_amount_reg;
  logic [3:0]  rc_div_reg;
  logic        start_pulse;
  logic        clk_tick;
  logic        acq_active;
  logic        acq_done;
  logic [1:0]  conv_cnt_reg;
  logic        converting_reg;
  logic [15:0] filter_output;
  logic [7:0]  res_high;
  logic [7:0]  res_low;
  logic        wr_en;
  logic        rd_en;
  logic        addr_ok;
  logic        filt_mode;
  aaf_timing_t timing;
  aaf_result_t res;

  assign wr_en = psel && penable && pwrite;
  assign rd_en = psel && penable && !pwrite;
  assign filt_mode = (mode_reg == 3'(AAF_MODE_LPF)) || (mode_reg == 3'(AAF_MODE_AVERAGE))
                   || (mode_reg == 3'(AAF_MODE_BURST));

  always_comb begin
    unique case (paddr)
      AAF_OFF_ACQ_LOW, AAF_OFF_ACQ_HIGH, AAF_OFF_PRE_LOW, AAF_OFF_PRE_HIGH,
      AAF_OFF_CAP, AAF_OFF_RPT, AAF_OFF_CNT, AAF_OFF_FLT_HIGH, AAF_OFF_FLT_LOW,
      AAF_OFF_RES_HIGH, AAF_OFF_RES_LOW, AAF_OFF_CTRL, AAF_OFF_STATUS,
      AAF_OFF_ACC_LOW, AAF_OFF_ACC_MID, AAF_OFF_ACC_UP: addr_ok = 1'b1;
      default: addr_ok = 1'b0;
    endcase
  end

  // Configuration registers written by software
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      acq_low_reg                 <= AAF_RST_BYTE;
      acq_high_reg                <= 5'h00;
      pre_low_reg                 <= AAF_RST_BYTE;
      pre_high_reg                <= 5'h00;
      cap_reg                     <= 5'h00;
      repeat_threshold_reg        <= AAF_RST_BYTE;
      result_justify_select_reg   <= 1'b0;
      conversion_clock_select_reg <= 1'b0;
      mode_reg                    <= 3'(AAF_MODE_BASIC);
      result_shift_amount_reg     <= 4'h0;
    end else if (wr_en) begin
      unique case (paddr)
        AAF_OFF_ACQ_LOW:  acq_low_reg  <= pwdata[7:0];
        AAF_OFF_ACQ_HIGH: acq_high_reg <= pwdata[4:0] & AAF_FIELD5_MSK;
        AAF_OFF_PRE_LOW:  pre_low_reg  <= pwdata[7:0];
        AAF_OFF_PRE_HIGH: pre_high_reg <= pwdata[4:0];
        AAF_OFF_CAP:      cap_reg      <= pwdata[4:0];
        AAF_OFF_RPT:      repeat_threshold_reg <= pwdata[7:0];
        AAF_OFF_CTRL: begin
          result_justify_select_reg   <= pwdata[AAF_CTRL_JUST_BIT];
          conversion_clock_select_reg <= pwdata[AAF_CTRL_CLK_BIT];
          mode_reg                    <= pwdata[AAF_CTRL_MODE_LSB +: 3];
          result_shift_amount_reg     <= pwdata[AAF_CTRL_SHIFT_LSB +: 4];
        end
        default: ;
      endcase
    end
  end

  assign start_pulse = wr_en && (paddr == AAF_OFF_CTRL) && pwdata[AAF_CTRL_START_BIT];
  assign timing = '{acq_count: {acq_high_reg, acq_low_reg},
                    pre_count: {pre_high_reg, pre_low_reg},
                    clk_is_rc: conversion_clock_select_reg};

  // RC clock is modelled as a divided tick; system clock ticks every cycle
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      rc_div_reg <= 4'h0;
    end else if (rc_div_reg == 4'(RC_DIV - 1)) begin
      rc_div_reg <= 4'h0;
    end else begin
      rc_div_reg <= rc_div_reg + 4'h1;
    end
  end
  assign clk_tick = conversion_clock_select_reg ? (rc_div_reg == 4'(RC_DIV - 1)) : 1'b1;

  aaf_acq_timer u_acq (
    .pclk       (pclk),
    .presetn    (presetn),
    .start      (start_pulse),
    .timing     (timing),
    .clk_tick   (clk_tick),
    .acq_active (acq_active),
    .acq_done   (acq_done)
  );

  // Conversion starts when acquisition expires
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      conv_start     <= 1'b0;
      converting_reg <= 1'b0;
      conv_cnt_reg   <= 2'h0;
    end else begin
      conv_start <= acq_done;
      if (acq_done) begin
        converting_reg <= 1'b1;
        conv_cnt_reg   <= AAF_CONV_CYC;
      end else if (converting_reg) begin
        conv_cnt_reg <= conv_cnt_reg - 2'h1;
        if (conv_cnt_reg == 2'h1) begin
          converting_reg <= 1'b0;
        end
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      extra_sample_capacitance <= 5'h00;
    end else begin
      extra_sample_capacitance <= cap_reg;
    end
  end

  // Result, running sum, low-pass value and repeat counter
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      conversion_result_reg      <= 12'h000;
      running_sum_reg            <= 18'h0_0000;
      lpf_reg                    <= 16'h0000;
      trigger_repeat_counter_reg <= AAF_RST_BYTE;
      threshold_check            <= 1'b0;
    end else begin
      threshold_check <= 1'b0;
      if (conv_valid) begin
        conversion_result_reg <= conv_data;
        running_sum_reg <= (mode_reg == 3'(AAF_MODE_BASIC)) ? 18'h0_0000
                         : running_sum_reg + {6'h00, conv_data};
        lpf_reg <= lpf_reg - (lpf_reg >> result_shift_amount_reg) + {4'h0, conv_data};
      end else if (wr_en && paddr == AAF_OFF_ACC_LOW) begin
        running_sum_reg <= 18'h0_0000;
      end
      if (wr_en && paddr == AAF_OFF_CNT) begin
        trigger_repeat_counter_reg <= pwdata[7:0];
      end else if (conv_trigger) begin
        if (filt_mode && trigger_repeat_counter_reg + 8'h01 >= repeat_threshold_reg) begin
          threshold_check            <= 1'b1;
          trigger_repeat_counter_reg <= AAF_RST_BYTE;
        end else begin
          trigger_repeat_counter_reg <= trigger_repeat_counter_reg + 8'h01;
        end
      end
    end
  end

  always_comb begin
    if (mode_reg == 3'(AAF_MODE_LPF)) begin
      filter_output = lpf_reg;
    end else begin
      filter_output = 16'(running_sum_reg >> result_shift_amount_reg);
    end
  end

  assign res = '{result: conversion_result_reg, just_right: result_justify_select_reg};

  aaf_result_fmt u_fmt (
    .res      (res),
    .res_high (res_high),
    .res_low  (res_low)
  );

  // APB read path, answers in the access cycle; unmapped address gives slverr
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata  <= 32'h0000_0000;
      pready  <= 1'b0;
      pslverr <= 1'b0;
    end else begin
      pready  <= psel && !penable;
      pslverr <= psel && !penable && !addr_ok;
      prdata  <= 32'h0000_0000;
      if (psel && !penable && !pwrite) begin
        unique case (paddr)
          AAF_OFF_ACQ_LOW:  prdata <= {24'h00_0000, acq_low_reg};
          AAF_OFF_ACQ_HIGH: prdata <= {27'h000_0000, acq_high_reg};
          AAF_OFF_PRE_LOW:  prdata <= {24'h00_0000, pre_low_reg};
          AAF_OFF_PRE_HIGH: prdata <= {27'h000_0000, pre_high_reg};
          AAF_OFF_CAP:      prdata <= {27'h000_0000, cap_reg};
          AAF_OFF_RPT:      prdata <= {24'h00_0000, repeat_threshold_reg};
          AAF_OFF_CNT:      prdata <= {24'h00_0000, trigger_repeat_counter_reg};
          AAF_OFF_FLT_HIGH: prdata <= {24'h00_0000, filter_output[15:8]};
          AAF_OFF_FLT_LOW:  prdata <= {24'h00_0000, filter_output[7:0]};
          AAF_OFF_RES_HIGH: prdata <= {24'h00_0000, res_high};
          AAF_OFF_RES_LOW:  prdata <= {24'h00_0000, res_low};
          AAF_OFF_CTRL:     prdata <= {20'h0_0000, result_shift_amount_reg, 1'b0, mode_reg,
                                       1'b0, conversion_clock_select_reg,
                                       result_justify_select_reg, 1'b0};
          AAF_OFF_STATUS:   prdata <= {30'h0000_0000, converting_reg, acq_active};
          AAF_OFF_ACC_LOW:  prdata <= {24'h00_0000, running_sum_reg[7:0]};
          AAF_OFF_ACC_MID:  prdata <= {24'h00_0000, running_sum_reg[15:8]};
          AAF_OFF_ACC_UP:   prdata <= {30'h0000_0000, running_sum_reg[17:16]};
          default:          prdata <= 32'h0000_0000;
        endcase
      end
    end
  end

  // Guard helpers: length of the running acquisition phase and what it should be
  logic        acq_sys_reg;
  logic [13:0] acq_len_reg;
  logic [13:0] acq_want_reg;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      acq_sys_reg  <= 1'b0;
      acq_len_reg  <= 14'h0000;
      acq_want_reg <= 14'h0000;
    end else if (start_pulse && !acq_active) begin
      acq_sys_reg <= !pwdata[AAF_CTRL_CLK_BIT];
      acq_len_reg <= 14'h0000;
      if (timing.acq_count != AAF_ACQ_ZERO) begin
        acq_want_reg <= {1'b0, timing.acq_count};
      end else if (timing.pre_count != AAF_ACQ_ZERO) begin
        acq_want_reg <= AAF_ACQ_LONG;
      end else begin
        acq_want_reg <= 14'h0000;
      end
    end else if (acq_active) begin
      acq_len_reg <= acq_len_reg + 14'h0001;
    end
  end

  // Guards
  sequence s_start_zero;
    start_pulse && !acq_active && timing.acq_count == AAF_ACQ_ZERO
      && timing.pre_count == AAF_ACQ_ZERO;
  endsequence

  // The clock select written along with start is the one the phase runs on
  sequence s_sys_start;
    start_pulse && !acq_active && !pwdata[AAF_CTRL_CLK_BIT];
  endsequence

  sequence s_flt_high_read;
    pready && !$past(pwrite) && $past(paddr) == AAF_OFF_FLT_HIGH;
  endsequence

  a_skip_acq_phase: assert property (@(posedge pclk) disable iff (!presetn)
    s_start_zero |=> acq_done && !acq_active)
    else $error("zero counts did not skip acquisition");

  a_acq_one_cycle: assert property (@(posedge pclk) disable iff (!presetn)
    s_sys_start ##0 timing.acq_count == 13'h0001 |=> acq_active ##1 acq_done)
    else $error("count of one did not give one period");

  a_acq_three: assert property (@(posedge pclk) disable iff (!presetn)
    s_sys_start ##0 timing.acq_count == 13'h0003 |=> acq_active [*3] ##1 acq_done)
    else $error("count of three wrong length");

  a_acq_length: assert property (@(posedge pclk) disable iff (!presetn)
    acq_done && acq_sys_reg && acq_want_reg != 14'h0000 |-> acq_len_reg == acq_want_reg)
    else $error("acquisition phase length wrong");

  a_conv_follows: assert property (@(posedge pclk) disable iff (!presetn)
    acq_done |=> conv_start)
    else $error("conversion did not start after acquisition");

  a_acqh_upper_zero: assert property (@(posedge pclk) disable iff (!presetn)
    pready && $past(paddr) == AAF_OFF_ACQ_HIGH |-> prdata[7:5] == 3'h0)
    else $error("acquisition high upper bits not zero");

  a_cap_follows: assert property (@(posedge pclk) disable iff (!presetn)
    wr_en && paddr == AAF_OFF_CAP |=> ##1 extra_sample_capacitance == $past(pwdata[4:0], 2))
    else $error("capacitance code not applied");

  a_right_just_high: assert property (@(posedge pclk) disable iff (!presetn)
    result_justify_select_reg |-> res_high == {4'h0, conversion_result_reg[11:8]})
    else $error("right justified high byte wrong");

  a_left_just_low: assert property (@(posedge pclk) disable iff (!presetn)
    !result_justify_select_reg |-> res_low[3:0] == 4'h0
      && res_low[7:4] == conversion_result_reg[3:0])
    else $error("left justified low byte wrong");

  a_lpf_output: assert property (@(posedge pclk) disable iff (!presetn)
    s_flt_high_read ##0 $past(mode_reg) == 3'(AAF_MODE_LPF)
      |-> prdata[7:0] == $past(lpf_reg[15:8]))
    else $error("filter output not low-pass value");

  a_thr_filt_only: assert property (@(posedge pclk) disable iff (!presetn)
    threshold_check |-> $past(filt_mode))
    else $error("threshold check outside filter modes");

  a_cnt_restart: assert property (@(posedge pclk) disable iff (!presetn)
    threshold_check |-> trigger_repeat_counter_reg == AAF_RST_BYTE)
    else $error("repeat counter not restarted at check");
endmodule : aaf_regs
`default_nettype wire

//--- aaf_pkg.sv
package aaf_pkg;
  // Register byte offsets on APB
  localparam logic [7:0] AAF_OFF_ACQ_LOW   = 8'h00;
  localparam logic [7:0] AAF_OFF_ACQ_HIGH  = 8'h04;
  localparam logic [7:0] AAF_OFF_PRE_LOW   = 8'h08;
  localparam logic [7:0] AAF_OFF_PRE_HIGH  = 8'h0C;
  localparam logic [7:0] AAF_OFF_CAP       = 8'h10;
  localparam logic [7:0] AAF_OFF_RPT       = 8'h14;
  localparam logic [7:0] AAF_OFF_CNT       = 8'h18;
  localparam logic [7:0] AAF_OFF_FLT_HIGH  = 8'h1C;
  localparam logic [7:0] AAF_OFF_FLT_LOW   = 8'h20;
  localparam logic [7:0] AAF_OFF_RES_HIGH  = 8'h24;
  localparam logic [7:0] AAF_OFF_RES_LOW   = 8'h28;
  localparam logic [7:0] AAF_OFF_CTRL      = 8'h2C;
  localparam logic [7:0] AAF_OFF_STATUS    = 8'h30;
  localparam logic [7:0] AAF_OFF_ACC_LOW   = 8'h34;
  localparam logic [7:0] AAF_OFF_ACC_MID   = 8'h38;
  localparam logic [7:0] AAF_OFF_ACC_UP    = 8'h3C;
  // Control register field positions
  localparam int AAF_CTRL_START_BIT = 0;
  localparam int AAF_CTRL_JUST_BIT  = 1;
  localparam int AAF_CTRL_CLK_BIT   = 2;
  localparam int AAF_CTRL_MODE_LSB  = 4;
  localparam int AAF_CTRL_SHIFT_LSB = 8;
  // Reset values and counts
  localparam logic [7:0]  AAF_RST_BYTE   = 8'h00;
  localparam logic [12:0] AAF_ACQ_ZERO   = 13'h0000;
  localparam logic [13:0] AAF_ACQ_LONG   = 14'h2000;
  localparam logic [3:0]  AAF_RC_DIV     = 4'h8;
  localparam logic [1:0]  AAF_CONV_CYC   = 2'h3;
  localparam logic [4:0]  AAF_FIELD5_MSK = 5'h1F;

  typedef enum logic [2:0] {
    AAF_MODE_BASIC,
    AAF_MODE_ACCUM,
    AAF_MODE_AVERAGE,
    AAF_MODE_BURST,
    AAF_MODE_LPF
  } aaf_mode_t;

  typedef struct packed {
    logic [12:0] acq_count;
    logic [12:0] pre_count;
    logic        clk_is_rc;
  } aaf_timing_t;

  typedef struct packed {
    logic [11:0] result;
    logic        just_right;
  } aaf_result_t;
endpackage : aaf_pkg

//--- aaf_acq_timer.sv
`timescale 1ns/1ns
`default_nettype none
module aaf_acq_timer (
  // Clock and reset
  input  wire logic              pclk,
  input  wire logic              presetn,
  // Control
  input  wire logic              start,
  input  wire aaf_pkg::aaf_timing_t timing,
  input  wire logic              clk_tick,
  // Status
  output logic                   acq_active,
  output logic                   acq_done
);
  import aaf_pkg::*;

  logic [13:0] count_reg;
  logic [13:0] load_value;

  always_comb begin
    if (timing.acq_count != AAF_ACQ_ZERO) begin
      load_value = {1'b0, timing.acq_count};
    end else if (timing.pre_count != AAF_ACQ_ZERO) begin
      load_value = AAF_ACQ_LONG;
    end else begin
      load_value = 14'h0000;
    end
  end

  // Down-counter loaded at start, decremented per selected clock period
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      count_reg  <= 14'h0000;
      acq_active <= 1'b0;
      acq_done   <= 1'b0;
    end else begin
      acq_done <= 1'b0;
      if (start && !acq_active) begin
        if (load_value == 14'h0000) begin
          acq_done <= 1'b1;
        end else begin
          count_reg  <= load_value;
          acq_active <= 1'b1;
        end
      end else if (acq_active && clk_tick) begin
        count_reg <= count_reg - 14'h0001;
        if (count_reg == 14'h0001) begin
          acq_active <= 1'b0;
          acq_done   <= 1'b1;
        end
      end
    end
  end
endmodule : aaf_acq_timer
`default_nettype wire

//--- aaf_result_fmt.sv
`timescale 1ns/1ns
`default_nettype none
module aaf_result_fmt (
  // Input
  input  wire aaf_pkg::aaf_result_t res,
  // Formatted bytes
  output logic [7:0]              res_high,
  output logic [7:0]              res_low
);
  import aaf_pkg::*;

  always_comb begin
    if (res.just_right) begin
      res_high = {4'h0, res.result[11:8]};
      res_low  = res.result[7:0];
    end else begin
      res_high = res.result[11:4];
      res_low  = {res.result[3:0], 4'h0};
    end
  end
endmodule : aaf_result_fmt
`default_nettype wire

//--- tb_top.sv
`timescale 1ns/1ns
`default_nettype none
module tb_top;
  import aaf_pkg::*;
  localparam int RC_DIV_TB = 4;
  typedef struct packed {
    logic [31:0] data;
    logic [31:0] mask;
    logic        err;
  } aaf_exp_t;
  logic        pclk, presetn, psel, penable, pwrite, conv_trigger, conv_valid;
  logic [7:0]  paddr;
  logic [31:0] pwdata, prdata, sum, flt;
  logic [11:0] conv_data, d;
  logic [15:0] lp;
  logic        pready, pslverr, conv_start, threshold_check;
  logic [4:0]  extra_sample_capacitance, cap;
  aaf_exp_t    exp_q[$];
  aaf_exp_t    e;
  int          err_total, total_checks, cycles, thr_seen, base, a, b, c, z;

  aaf_regs #(.RC_DIV(RC_DIV_TB)) dut_u (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .conv_trigger(conv_trigger), .conv_valid(conv_valid), .conv_data(conv_data),
    .conv_start(conv_start), .extra_sample_capacitance(extra_sample_capacitance),
    .threshold_check(threshold_check));

  always #20 pclk = ~pclk;

  task report_and_stop();
    $display("checks %0d errors %0d", total_checks, err_total);
    if (err_total == 0 && total_checks > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask : report_and_stop

  task fail(input string m);
    err_total++;
    $display("[FAIL] %0t %s", $time, m);
  endtask : fail

  task check_val(input logic [31:0] got, input logic [31:0] exp, input string m);
    total_checks++;
    if (got !== exp) fail(m);
  endtask : check_val

  task check_bus(input aaf_exp_t x);
    check_val(prdata & x.mask, x.data & x.mask, "read data");
    check_val({31'h0, pslverr}, {31'h0, x.err}, "slave error");
  endtask : check_bus

  // Oldest expectation is taken off whenever the slave answers
  always @(posedge pclk) begin
    if (psel === 1'b1 && penable === 1'b1 && pready === 1'b1) begin
      if (exp_q.size() == 0) fail("answer without request");
      else begin
        e = exp_q.pop_front();
        check_bus(e);
      end
    end
  end

  always @(posedge pclk) begin
    if (threshold_check === 1'b1) thr_seen <= thr_seen + 1;
  end

  always @(posedge pclk) begin
    cycles <= cycles + 1;
    if (cycles == 60000) begin
      fail("timeout");
      report_and_stop();
    end
  end

  task apb(input logic wr, input logic [7:0] ad, input logic [31:0] wd,
           input logic [31:0] ex, input logic [31:0] m);
    exp_q.push_back('{ex, m, (ad > AAF_OFF_ACC_UP) || (ad[1:0] != 2'b00)});
    @(posedge pclk);
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= wr;
    paddr   <= ad;
    pwdata  <= wd;
    @(posedge pclk);
    penable <= 1'b1;
    do begin
      @(posedge pclk);
    end while (pready !== 1'b1);
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask : apb

  task wr(input logic [7:0] ad, input logic [31:0] wd);
    apb(1'b1, ad, wd, 32'h0000_0000, 32'h0000_0000);
  endtask : wr

  task rd(input logic [7:0] ad, input logic [31:0] ex, input logic [31:0] m);
    apb(1'b0, ad, 32'h0000_0000, ex, m);
  endtask : rd

  function automatic logic [31:0] ctrl(input logic st, input logic rj, input logic rc,
                                       input logic [2:0] md, input logic [3:0] sh);
    return {20'h0_0000, sh, 1'b0, md, 1'b0, rc, rj, st};
  endfunction : ctrl

  task pulse(input logic tg, input logic vl, input logic [11:0] dv);
    @(posedge pclk);
    conv_trigger <= tg;
    conv_valid   <= vl;
    conv_data    <= dv;
    @(posedge pclk);
    conv_trigger <= 1'b0;
    conv_valid   <= 1'b0;
    repeat (3) @(posedge pclk);
  endtask : pulse

  // Cycles from the start write edge until conv_start is seen
  task measure(input logic [12:0] acq, input logic [12:0] pre, input logic rc, output int n);
    wr(AAF_OFF_ACQ_LOW, {24'h00_0000, acq[7:0]});
    wr(AAF_OFF_ACQ_HIGH, {27'h000_0000, acq[12:8]});
    wr(AAF_OFF_PRE_LOW, {24'h00_0000, pre[7:0]});
    wr(AAF_OFF_PRE_HIGH, {27'h000_0000, pre[12:8]});
    wr(AAF_OFF_CTRL, ctrl(1'b1, 1'b0, rc, 3'h0, 4'h0));
    n = 0;
    while (conv_start !== 1'b1 && n < 20000) begin
      @(posedge pclk);
      #1;
      n++;
    end
    repeat (4) @(posedge pclk);
  endtask : measure

  initial begin
    pclk = 0; presetn = 0; psel = 0; penable = 0; pwrite = 0; paddr = 8'h00;
    pwdata = 32'h0000_0000; conv_trigger = 0; conv_valid = 0; conv_data = 12'h000;
    err_total = 0; total_checks = 0; cycles = 0; thr_seen = 0;
    void'($urandom(32'h9873));
    repeat (16) @(posedge pclk);
    presetn <= 1'b1;
    rd(AAF_OFF_ACQ_HIGH, 32'h0000_0000, 32'hFFFF_FFFF);
    rd(AAF_OFF_CAP, 32'h0000_0000, 32'hFFFF_FFFF);
    rd(AAF_OFF_RPT, 32'h0000_0000, 32'hFFFF_FFFF);
    wr(AAF_OFF_ACQ_HIGH, 32'h0000_00FF);
    rd(AAF_OFF_ACQ_HIGH, 32'h0000_001F, 32'hFFFF_FFFF);
    wr(AAF_OFF_ACQ_LOW, 32'h0000_00A5);
    rd(AAF_OFF_ACQ_LOW, 32'h0000_00A5, 32'hFFFF_FFFF);
    for (int i = 0; i < 5; i++) begin
      cap = (i == 0) ? 5'h00 : 5'($urandom % 32);
      wr(AAF_OFF_CAP, {24'hFF_FFFF, 3'h7, cap});
      rd(AAF_OFF_CAP, {27'h000_0000, cap}, 32'hFFFF_FFFF);
      check_val({27'h0, extra_sample_capacitance}, {27'h0, cap}, "capacitance code");
    end
    rd(8'h40, 32'h0000_0000, 32'hFFFF_FFFF);
    wr(8'hFC, 32'h0000_0055);
    measure(13'h0000, 13'h0000, 1'b0, z);
    check_val(z, 1, "zero counts skip acquisition");
    measure(13'h0003, 13'h0000, 1'b0, a);
    measure(13'h0007, 13'h0000, 1'b0, b);
    check_val(b - a, 4, "acquisition count periods");
    measure(13'h0001, 13'h0000, 1'b0, a);
    measure(13'h1FFF, 13'h0000, 1'b0, b);
    check_val(b - a, 8190, "longest acquisition count");
    measure(13'h0001, 13'h0001, 1'b0, a);
    measure(13'h0000, 13'h0001, 1'b0, b);
    check_val(b - a, 8191, "zero count with precharge");
    measure(13'h0003, 13'h0000, 1'b1, a);
    measure(13'h0005, 13'h0000, 1'b1, b);
    c = b - a;
    check_val(c >= RC_DIV_TB + 1 && c <= 3 * RC_DIV_TB - 1, 1, "slow clock periods");
    for (int md = 2; md <= 4; md++) begin
      wr(AAF_OFF_CTRL, ctrl(1'b0, 1'b0, 1'b0, 3'(md), 4'h0));
      wr(AAF_OFF_RPT, 32'h0000_0003);
      wr(AAF_OFF_CNT, 32'h0000_0000);
      base = thr_seen;
      pulse(1'b1, 1'b0, 12'h000);
      pulse(1'b1, 1'b0, 12'h000);
      check_val(thr_seen - base, 0, "early threshold check");
      rd(AAF_OFF_CNT, 32'h0000_0002, 32'hFFFF_FFFF);
      pulse(1'b1, 1'b0, 12'h000);
      check_val(thr_seen - base, 1, "threshold check at count");
      rd(AAF_OFF_CNT, 32'h0000_0000, 32'hFFFF_FFFF);
    end
    wr(AAF_OFF_CTRL, ctrl(1'b0, 1'b0, 1'b0, 3'h1, 4'h2));
    wr(AAF_OFF_ACC_LOW, 32'h0000_0000);
    sum = 32'h0000_0000;
    base = thr_seen;
    for (int i = 0; i < 4; i++) begin
      d = 12'($urandom % 4096);
      pulse(1'b1, 1'b1, d);
      sum = sum + {20'h0_0000, d};
      flt = sum >> 2;
      rd(AAF_OFF_FLT_HIGH, {24'h00_0000, flt[15:8]}, 32'hFFFF_FFFF);
      rd(AAF_OFF_FLT_LOW, {24'h00_0000, flt[7:0]}, 32'hFFFF_FFFF);
    end
    check_val(thr_seen - base, 0, "threshold check outside filter modes");
    wr(AAF_OFF_FLT_LOW, {24'h00_0000, ~flt[7:0]});
    rd(AAF_OFF_FLT_LOW, {24'h00_0000, flt[7:0]}, 32'hFFFF_FFFF);
    for (int j = 0; j < 2; j++) begin
      wr(AAF_OFF_CTRL, ctrl(1'b0, j[0], 1'b0, 3'h0, 4'h0));
      d = 12'($urandom % 4096);
      pulse(1'b0, 1'b1, d);
      if (j == 0) begin
        rd(AAF_OFF_RES_HIGH, {24'h00_0000, d[11:4]}, 32'hFFFF_FFFF);
        rd(AAF_OFF_RES_LOW, {24'h00_0000, d[3:0], 4'h0}, 32'hFFFF_FFF0);
      end else begin
        rd(AAF_OFF_RES_HIGH, {28'h000_0000, d[11:8]}, 32'hFFFF_FFFF);
        rd(AAF_OFF_RES_LOW, {24'h00_0000, d[7:0]}, 32'hFFFF_FFFF);
      end
    end
    d = 12'($urandom % 4096);
    wr(AAF_OFF_CTRL, ctrl(1'b0, 1'b0, 1'b0, 3'h4, 4'h0));
    pulse(1'b0, 1'b1, d);
    lp = {4'h0, d};
    d = 12'($urandom % 4096);
    wr(AAF_OFF_CTRL, ctrl(1'b0, 1'b0, 1'b0, 3'h4, 4'h1));
    pulse(1'b0, 1'b1, d);
    lp = lp - (lp >> 1) + {4'h0, d};
    rd(AAF_OFF_FLT_HIGH, {24'h00_0000, lp[15:8]}, 32'hFFFF_FFFF);
    rd(AAF_OFF_FLT_LOW, {24'h00_0000, lp[7:0]}, 32'hFFFF_FFFF);
    repeat (4) @(posedge pclk);
    check_val(exp_q.size(), 0, "unanswered requests");
    report_and_stop();
  end
endmodule : tb_top
`default_nettype wire
